// File: dbf_cfg.svh
`ifndef DBF_CFG_SVH
`define DBF_CFG_SVH

// opcode byte values
`define DBF_OPC_BR_LOWER 8'he4
`define DBF_OPC_BR_OVF   8'he0
`define DBF_OPC_BR_EQ    8'he2
`define DBF_OPC_FLOAT_ADD_SINGLE_S   8'hc0
`define DBF_OPC_FLOAT_ADD_SINGLE_D   8'hc1
`define DBF_OPC_FLOAT_COMPARE_SINGLE_S   8'hc8
`define DBF_OPC_FLOAT_COMPARE_SINGLE_D   8'hc9

// instruction halfword fields
`define DBF_OPC_HI       15
`define DBF_OPC_LO       8
`define DBF_BR_ZERO_BIT  7
`define DBF_REL_HI       6
`define DBF_REL_LO       1
`define DBF_REL_SIGN     0
`define DBF_LD_HI        7
`define DBF_LD_LO        4
`define DBF_LS_HI        3
`define DBF_LS_LO        0

// operand fields
`define DBF_NAN_HI       30
`define DBF_NAN_LO       19
`define DBF_SIGN_BIT     31

// flag register bits
`define DBF_FLG_C        0
`define DBF_FLG_Z        1
`define DBF_FLG_N        2
`define DBF_FLG_V        3
`define DBF_FLG_M        4
`define DBF_FLG_W        5

// register byte addresses
`define DBF_AW           12
`define DBF_A_FLAGS      12'h000
`define DBF_A_PC         12'h004
`define DBF_A_STATUS     12'h008
`define DBF_A_TRAP       12'h00c
`define DBF_A_TRAP_CLR   12'h010
`define DBF_A_RES_LO     12'h014
`define DBF_A_RES_HI     12'h018
`define DBF_A_COMMIT     12'h01c
`define DBF_A_LREG_IDX   12'h020
`define DBF_A_LREG_DATA  12'h024

// reset values and steps
`define DBF_PC_RST       32'h0000_0000
`define DBF_HALF_BYTES   32'h0000_0002
`define DBF_ILC_HALF     2'h1
`define DBF_EXC_INVALID  5'h01
`define DBF_EXC_ALL      5'h1f
`define DBF_EXC_NONE     5'h00

`endif

// File: dbf_decoder.sv
// What this block does
// RULE1: e4 with bit7 clear branches when carry
// RULE2: e0 with bit7 clear branches when overflow
// RULE3: e2 with bit7 clear branches when zero
// RULE4: displacement is sign, six bits, zero lsb
// RULE5: target is next instruction plus displacement
// RULE6: branches never touch flags or cache mode
// RULE7: instruction after branch always executes
// RULE8: untaken slot advances pc and length code
// RULE9: taken slot keeps pc at target
// RULE10: slot reading pc sees the target
// RULE11: c0 is single add, dest and source fields
// RULE12: single add writes sum into destination
// RULE13: double add uses register pairs
// RULE14: float adds leave flags untouched
// RULE15: float ops trap to software emulation
// RULE16: program keeps float ops out of slots
// RULE17: nan means exponent bits 30..19 all ones
// RULE18: float add may raise all five exceptions
// RULE19: c8 is single compare, dest minus source
// RULE20: compare raises invalid only when unordered
// RULE21: differing operand types are unordered, invalid
// RULE22: double compare zero, negative, carry, overflow
// RULE23: redirect fetch only after slot issued
`timescale 1ns/1ps
`include "dbf_cfg.svh"
module dbf_decoder (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [`DBF_AW-1:0]  paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                instr_valid,
   input  wire logic [15:0]         instr_data,
   output logic                     instr_ready,
   output logic                     fetch_redirect,
   output logic      [31:0]         fetch_target,
   output logic                     delay_slot,
   output logic                     trap_req
);
   dbf_fp_if fp ();

   dbf_pkg::dbf_state_e         state;        // run or waiting for slot
   dbf_pkg::dbf_state_e         next_state;
   dbf_pkg::dbf_op_e            op;           // decode of the fetch word
   dbf_pkg::dbf_trap_s          trap_rec;     // held for the handler
   logic [31:0]                 program_counter;
   logic [31:0]                 next_pc;
   logic [1:0]                  instruction_length_code;
   logic [`DBF_FLG_W-1:0]       flags;        // c z n v m
   logic                        taken;        // pending branch is taken
   logic                        next_taken;
   logic                        next_redirect;
   logic                        trap;         // emulation pending
   logic                        next_trap;
   logic                        slot_viol;    // float op found in a slot
   logic [31:0]                 res_lo;       // emulated result words
   logic [31:0]                 res_hi;
   logic [3:0]                  lreg_idx;
   logic [31:0]                 lreg [16];    // local registers
   logic [31:0]                 rel;
   logic [3:0]                  ld;
   logic [3:0]                  ls;
   logic                        cond;
   logic                        acc;
   logic                        setup;
   logic                        wr_acc;
   logic                        commit;
   logic                        commit_dbl;
   logic [31:0]                 rd_word;

   // decode one fetch halfword
   function automatic dbf_pkg::dbf_op_e dbf_decode(
      input logic [15:0] w
   );
      logic [7:0] opc;
      dbf_pkg::dbf_op_e r;
      opc = w[`DBF_OPC_HI:`DBF_OPC_LO];
      r   = dbf_pkg::OP_NONE;
      // branches need the zero bit below the opcode
      if (!w[`DBF_BR_ZERO_BIT]) begin
         if (opc == `DBF_OPC_BR_LOWER) begin
            r = dbf_pkg::OP_BR_LOWER;  // RULE1
         end else if (opc == `DBF_OPC_BR_OVF) begin
            r = dbf_pkg::OP_BR_OVF;    // RULE2
         end else if (opc == `DBF_OPC_BR_EQ) begin
            r = dbf_pkg::OP_BR_EQ;     // RULE3
         end
      end
      if (opc == `DBF_OPC_FLOAT_ADD_SINGLE_S) begin
         r = dbf_pkg::OP_FLOAT_ADD_SINGLE_S;       // RULE11
      end else if (opc == `DBF_OPC_FLOAT_ADD_SINGLE_D) begin
         r = dbf_pkg::OP_FLOAT_ADD_SINGLE_D;
      end else if (opc == `DBF_OPC_FLOAT_COMPARE_SINGLE_S) begin
         r = dbf_pkg::OP_FLOAT_COMPARE_SINGLE_S;       // RULE19
      end else if (opc == `DBF_OPC_FLOAT_COMPARE_SINGLE_D) begin
         r = dbf_pkg::OP_FLOAT_COMPARE_SINGLE_D;
      end
      return r;
   endfunction : dbf_decode

   // float ops all take the emulation path
   function automatic logic dbf_is_fp(input dbf_pkg::dbf_op_e o);
      return o == dbf_pkg::OP_FLOAT_ADD_SINGLE_S || o == dbf_pkg::OP_FLOAT_ADD_SINGLE_D ||
             o == dbf_pkg::OP_FLOAT_COMPARE_SINGLE_S || o == dbf_pkg::OP_FLOAT_COMPARE_SINGLE_D;
   endfunction : dbf_is_fp

   // double forms work on register pairs
   function automatic logic dbf_is_dbl(input dbf_pkg::dbf_op_e o);
      return o == dbf_pkg::OP_FLOAT_ADD_SINGLE_D || o == dbf_pkg::OP_FLOAT_COMPARE_SINGLE_D;
   endfunction : dbf_is_dbl

   // address decode used for the error answer only; the read mux decodes on its own
   function automatic logic dbf_mapped(input logic [`DBF_AW-1:0] a);
      return a == `DBF_A_FLAGS    || a == `DBF_A_PC      ||
             a == `DBF_A_STATUS   || a == `DBF_A_TRAP    ||
             a == `DBF_A_TRAP_CLR || a == `DBF_A_RES_LO  ||
             a == `DBF_A_RES_HI   || a == `DBF_A_COMMIT  ||
             a == `DBF_A_LREG_IDX || a == `DBF_A_LREG_DATA;
   endfunction : dbf_mapped

   // fetch word fields
   always_comb begin
      acc = instr_valid & instr_ready;
      op  = dbf_decode(instr_data);
      ld  = instr_data[`DBF_LD_HI:`DBF_LD_LO];
      ls  = instr_data[`DBF_LS_HI:`DBF_LS_LO];
      rel = {{25{instr_data[`DBF_REL_SIGN]}},
             instr_data[`DBF_REL_HI:`DBF_REL_LO], 1'b0};  // RULE4
   end

   // branch condition from the current flags
   always_comb begin
      case (op)
         dbf_pkg::OP_BR_LOWER: cond = flags[`DBF_FLG_C];  // RULE1
         dbf_pkg::OP_BR_OVF:   cond = flags[`DBF_FLG_V];  // RULE2
         dbf_pkg::OP_BR_EQ:    cond = flags[`DBF_FLG_Z];  // RULE3
         default:              cond = 1'b0;
      endcase
   end

   // operands go to the compare unit; pair partner wraps at 15
   always_comb begin
      if (dbf_is_dbl(op)) begin
         fp.dst = {lreg[ld], lreg[ld + 4'h1]};  // RULE13
         fp.src = {lreg[ls], lreg[ls + 4'h1]};  // RULE13
      end else begin
         fp.dst = {lreg[ld], 32'h0};
         fp.src = {lreg[ls], 32'h0};
      end
   end

   dbf_fp_cmp u_cmp (
      .fp (fp.cmp)
   );

   // sequencing of branch, slot and ordinary instructions
   always_comb begin
      next_pc       = program_counter;
      next_state    = state;
      next_taken    = taken;
      next_redirect = 1'b0;
      if (acc) begin
         case (state)
            dbf_pkg::ST_SLOT: begin
               // slot runs whatever it holds; its own branch is ignored
               next_state = dbf_pkg::ST_RUN;                    // RULE7
               if (taken) begin
                  next_redirect = 1'b1;                         // RULE23
               end else begin
                  next_pc = program_counter + `DBF_HALF_BYTES;  // RULE8
               end
            end
            default: begin
               next_pc = program_counter + `DBF_HALF_BYTES;
               if (op == dbf_pkg::OP_BR_LOWER ||
                   op == dbf_pkg::OP_BR_OVF ||
                   op == dbf_pkg::OP_BR_EQ) begin
                  next_state = dbf_pkg::ST_SLOT;                // RULE7
                  next_taken = cond;
                  if (cond) begin
                     next_pc = program_counter + `DBF_HALF_BYTES
                               + rel;                           // RULE5
                  end
               end
            end
         endcase
      end else if (wr_acc && paddr == `DBF_A_PC) begin
         next_pc = pwdata;
      end
   end

   // pc holds the target through a taken slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_counter <= `DBF_PC_RST;
         state           <= dbf_pkg::ST_RUN;
         taken           <= 1'b0;
      end else begin
         program_counter <= next_pc;  // RULE9 RULE10
         state           <= next_state;
         taken           <= next_taken;
      end
   end

   // length code reloads on every accepted word except the slot of a taken branch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instruction_length_code <= `DBF_ILC_HALF;
      end else if (acc && !(state == dbf_pkg::ST_SLOT && taken)) begin
         instruction_length_code <= `DBF_ILC_HALF;  // RULE8
      end
   end

   // redirect comes one edge after the slot is taken in
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_redirect <= 1'b0;
         fetch_target   <= `DBF_PC_RST;
         delay_slot     <= 1'b0;
      end else begin
         fetch_redirect <= next_redirect;  // RULE23
         delay_slot     <= next_state == dbf_pkg::ST_SLOT;
         if (next_redirect) begin
            fetch_target <= program_counter;  // RULE9
         end
      end
   end

   // flags change only by software; no op here writes them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else if (wr_acc && paddr == `DBF_A_FLAGS) begin
         flags <= pwdata[`DBF_FLG_W-1:0];  // RULE6 RULE14
      end
   end

   // trap pending: new float op wins over a clear in the same cycle
   always_comb begin
      commit     = wr_acc && paddr == `DBF_A_COMMIT;
      commit_dbl = dbf_is_dbl(trap_rec.op);
      next_trap  = trap;
      if (commit || (wr_acc && paddr == `DBF_A_TRAP_CLR)) begin
         next_trap = 1'b0;
      end
      if (acc && dbf_is_fp(op)) begin
         next_trap = 1'b1;  // RULE15
      end
   end

   // stall fetch while the handler owns the float op
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap        <= 1'b0;
         trap_req    <= 1'b0;
         instr_ready <= 1'b1;
      end else begin
         trap        <= next_trap;
         trap_req    <= next_trap;
         instr_ready <= ~next_trap;
      end
   end

   // capture decode, operands class and allowed exceptions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_rec <= '0;
      end else if (acc && dbf_is_fp(op)) begin
         trap_rec.op <= op;
         trap_rec.ld <= ld;
         trap_rec.ls <= ls;
         trap_rec.z  <= fp.z;  // RULE22
         trap_rec.n  <= fp.n;
         trap_rec.c  <= fp.c;
         trap_rec.v  <= fp.v;
         if (op == dbf_pkg::OP_FLOAT_COMPARE_SINGLE_S || op == dbf_pkg::OP_FLOAT_COMPARE_SINGLE_D) begin
            trap_rec.exc <= fp.unord ? `DBF_EXC_INVALID
                                     : `DBF_EXC_NONE;  // RULE20 RULE21
         end else begin
            trap_rec.exc <= `DBF_EXC_ALL;  // RULE18
         end
      end
   end

   // sticky note that software broke the slot restriction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_viol <= 1'b0;
      end else if (acc && state == dbf_pkg::ST_SLOT && dbf_is_fp(op)) begin
         slot_viol <= 1'b1;  // RULE16
      end else if (wr_acc && paddr == `DBF_A_TRAP_CLR) begin
         slot_viol <= 1'b0;
      end
   end

   // result words and local register index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_lo   <= '0;
         res_hi   <= '0;
         lreg_idx <= '0;
      end else if (wr_acc) begin
         if (paddr == `DBF_A_RES_LO) begin
            res_lo <= pwdata;
         end else if (paddr == `DBF_A_RES_HI) begin
            res_hi <= pwdata;
         end else if (paddr == `DBF_A_LREG_IDX) begin
            lreg_idx <= pwdata[3:0];
         end
      end
   end

   // local registers; commit writes the destination, and for a double op also its pair
   for (genvar i = 0; i < 16; i++) begin : g_lreg
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            lreg[i] <= '0;
         end else if (commit && trap_rec.ld == 4'(i)) begin
            lreg[i] <= commit_dbl ? res_hi : res_lo;  // RULE12
         end else if (commit && commit_dbl &&
                      trap_rec.ld + 4'h1 == 4'(i)) begin
            lreg[i] <= res_lo;  // RULE13
         end else if (wr_acc && paddr == `DBF_A_LREG_DATA &&
                      lreg_idx == 4'(i)) begin
            lreg[i] <= pwdata;
         end
      end
   end

   // read mux
   always_comb begin
      if (paddr == `DBF_A_FLAGS) begin
         rd_word = {{(32-`DBF_FLG_W){1'b0}}, flags};
      end else if (paddr == `DBF_A_PC) begin
         rd_word = program_counter;  // RULE10
      end else if (paddr == `DBF_A_STATUS) begin
         rd_word = {22'h0, instruction_length_code, 4'h0, slot_viol,
                    trap, taken, state == dbf_pkg::ST_SLOT};
      end else if (paddr == `DBF_A_TRAP) begin
         rd_word = 32'(trap_rec);
      end else if (paddr == `DBF_A_RES_LO) begin
         rd_word = res_lo;
      end else if (paddr == `DBF_A_RES_HI) begin
         rd_word = res_hi;
      end else if (paddr == `DBF_A_LREG_IDX) begin
         rd_word = {28'h0, lreg_idx};
      end else if (paddr == `DBF_A_LREG_DATA) begin
         rd_word = lreg[lreg_idx];
      end else begin
         rd_word = '0;
      end
   end

   // apb: one wait-free access phase, answer registered at setup
   always_comb begin
      setup  = psel & ~penable;
      wr_acc = psel & penable & pready & pwrite;
   end

   // read data and error flag fixed before the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~dbf_mapped(paddr);
         prdata  <= (setup && !pwrite) ? rd_word : 32'h0;
      end
   end
endmodule : dbf_decoder

// File: dbf_decoder_monitor.sv
`timescale 1ns/1ps
// watches the decoder top ports only
module dbf_decoder_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        instr_valid,
   input wire logic [15:0] instr_data,
   input wire logic        instr_ready,
   input wire logic        fetch_redirect,
   input wire logic [31:0] fetch_target,
   input wire logic        delay_slot,
   input wire logic        trap_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // a branch word taken outside any slot
   sequence branch_in;
      instr_valid && instr_ready && !delay_slot && !instr_data[7] &&
      instr_data[15:8] inside {8'he4, 8'he0, 8'he2};
   endsequence
   // the slot word itself
   sequence slot_in;
      instr_valid && instr_ready && delay_slot;
   endsequence
   // a float op taken outside a slot
   sequence float_in;
      instr_valid && instr_ready && !delay_slot &&
      instr_data[15:8] inside {8'hc0, 8'hc1, 8'hc8, 8'hc9};
   endsequence
   // software ending the trap by clear or commit; a plain level, since
   // it is negated below and a sequence cannot be
   wire trap_end = psel && penable && pready && pwrite &&
      paddr inside {12'h010, 12'h01c};

   slot_opens_a: assert property (branch_in |=> delay_slot)
      else $error("no slot after branch");
   slot_closes_a: assert property (slot_in |=> !delay_slot)
      else $error("slot flag stuck");
   redirect_late_a: assert property (fetch_redirect |->
      $past(delay_slot) && $past(instr_valid) && $past(instr_ready))
      else $error("redirect before slot issued");
   redirect_pulse_a: assert property (
      fetch_redirect |=> !fetch_redirect)
      else $error("redirect longer than one cycle");
   float_trap_a: assert property (
      float_in |=> trap_req && !instr_ready)
      else $error("float op not trapped");
   trap_stall_a: assert property (trap_req |-> !instr_ready)
      else $error("fetch accepted during trap");
   trap_hold_a: assert property (
      trap_req && !trap_end |=> trap_req)
      else $error("trap dropped without software");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   apb_err_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   idle_data_a: assert property (
      !(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");
endmodule : dbf_decoder_monitor

bind dbf_decoder dbf_decoder_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
   .instr_data(instr_data), .instr_ready(instr_ready),
   .fetch_redirect(fetch_redirect), .fetch_target(fetch_target),
   .delay_slot(delay_slot), .trap_req(trap_req));

// File: dbf_decoder_tb.sv
`timescale 1ns/1ps
module dbf_decoder_tb;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, fetch_target, redir_tgt, fl, tgt;
   logic        pready, pslverr, instr_valid, instr_ready;
   logic        fetch_redirect, delay_slot, trap_req;
   logic [15:0] instr_data;
   logic [7:0]  rel;
   int          n_errors, n_compared, n_redir, snap, k, i;
   logic [7:0]  bop [3] = '{8'he4, 8'he0, 8'he2}; // branch opcodes
   int          fb [3]  = '{0, 3, 1};             // flag bit each tests
   logic [7:0]  brel [3] = '{8'h80, 8'h7e, 8'hfe}; // -128, 126, -2
   logic [31:0] lv [5] = '{32'h3ff0_0000, 0, 32'h4000_0000, 0,
                           32'h7ff8_0000};          // locals 3..7
   logic [15:0] fw [4] = '{16'hc875, 16'hc935, 16'hc035, 16'hc155};
   logic [31:0] fx [4] = '{32'hd2be, 32'h329f, 32'hf829c, 32'hf82ad};

   dbf_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_valid(instr_valid), .instr_data(instr_data),
      .instr_ready(instr_ready), .fetch_redirect(fetch_redirect),
      .fetch_target(fetch_target), .delay_slot(delay_slot),
      .trap_req(trap_req));
   dbf_fetch_model fm (.pclk(pclk), .presetn(presetn),
      .instr_ready(instr_ready), .instr_valid(instr_valid),
      .instr_data(instr_data));

   always #5 pclk = ~pclk;

   // count redirects and keep the last target
   always @(posedge pclk) begin
      if (fetch_redirect === 1'b1) begin
         n_redir++;
         redir_tgt = fetch_target;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                  seen, exp);
      end
   endtask : check

   // one apb transfer, waits for ready with a bound
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) n_errors++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(r & m, exp);
   endtask : rd

   // let queued words go, then the redirect cycle
   task automatic drain;
      for (int n = 0; n < 40 && fm.hd != fm.tl; n++) @(posedge pclk);
      repeat (2) @(posedge pclk);
   endtask : drain

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // watchdog far beyond the expected few hundred cycles
   initial begin
      #100us;
      n_errors++;
      finish_test();
   end

   initial begin
      logic [31:0] r;
      logic        e;
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      n_errors = 0; n_compared = 0; n_redir = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, 32'hffff_ffff, 32'h0);
      rd(12'h00c, 32'hffff_ffff, 32'h0);
      apb(1'b0, 12'h040, 32'h0, r, e); // unmapped place
      check(r, 32'h0);
      check(e, 1'b1);
      $display("test reset done");
      // each branch taken with only its own flag set, then not taken with all flags but its own set
      for (k = 0; k < 6; k++) begin
         i = k % 3;
         rel = brel[i];
         fl = (k < 3) ? (32'h1 << fb[i]) : (32'h1f & ~(32'h1 << fb[i]));
         tgt = (k < 3) ? 32'h102 + {{24{rel[7]}}, rel} : 32'h102;
         fm.slow = (k == 1);
         wr(12'h000, fl);
         wr(12'h004, 32'h100);
         snap = n_redir;
         fm.push({bop[i], 1'b0, rel[6:1], rel[7]});
         drain();
         rd(12'h004, 32'hffff_ffff, tgt);
         rd(12'h008, 32'h1, 32'h1);
         fm.push(16'h0000); // plain slot word, never a float op
         drain();
         rd(12'h004, 32'hffff_ffff, (k < 3) ? tgt : 32'h104);
         check(n_redir - snap, (k < 3));
         if (k < 3) check(redir_tgt, tgt);
         if (k >= 3) rd(12'h008, 32'h301, 32'h100);
         rd(12'h000, 32'h1f, fl);
      end
      $display("test branches done");
      for (k = 0; k < 5; k++) begin
         wr(12'h020, k + 3);
         wr(12'h024, lv[k]);
      end
      wr(12'h000, 32'h15);
      // compares first, then adds committed through software
      for (k = 0; k < 4; k++) begin
         fm.push(fw[k]);
         for (i = 0; i < 20 && trap_req !== 1'b1; i++) @(posedge pclk);
         check(trap_req, 1'b1);
         rd(12'h00c, (k < 2) ? 32'h1fffff : 32'hf87ff, fx[k]);
         if (k < 2) begin
            wr(12'h010, 32'h0);
         end else begin
            wr(12'h018, 32'haaaa_0001);
            wr(12'h014, 32'h5555_0002);
            wr(12'h01c, 32'h0);
         end
         rd(12'h008, 32'h4, 32'h0);
      end
      wr(12'h020, 32'h3);
      rd(12'h024, 32'hffff_ffff, 32'h5555_0002);
      wr(12'h020, 32'h5);
      rd(12'h024, 32'hffff_ffff, 32'haaaa_0001);
      wr(12'h020, 32'h6);
      rd(12'h024, 32'hffff_ffff, 32'h5555_0002);
      rd(12'h000, 32'h1f, 32'h15);
      $display("test float done");
      finish_test();
   end
endmodule : dbf_decoder_tb

// File: dbf_fetch_model.sv
`timescale 1ns/1ps
// program memory fetch stream feeding the decoder
module dbf_fetch_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        instr_ready,
   output logic             instr_valid,
   output logic [15:0]      instr_data
);
   logic [15:0] mem [0:63]; // queued halfwords
   int          hd = 0;     // next word to offer
   int          tl = 0;     // next free place
   bit          slow = 0;   // idle one cycle after each word

   // queue a halfword behind the others
   task automatic push(input logic [15:0] w);
      mem[tl[5:0]] = w;
      tl++;
   endtask : push

   // offer words in order, holding each until taken
   always @(posedge pclk or negedge presetn) begin
      bit gap;
      gap = 1'b0;
      if (!presetn) begin
         instr_valid <= 1'b0;
         instr_data  <= 16'h0000;
      end else begin
         if (instr_valid && instr_ready) begin
            hd++;
            gap = slow;
         end
         if (hd != tl && !gap) begin
            instr_valid <= 1'b1;
            instr_data  <= mem[hd[5:0]];
         end else begin
            // idle bus toggles so stale data is never mistaken
            instr_valid <= 1'b0;
            instr_data  <= ~instr_data;
         end
      end
   end
endmodule : dbf_fetch_model

// File: dbf_fp_cmp.sv
`timescale 1ns/1ps
`include "dbf_cfg.svh"
module dbf_fp_cmp (
   dbf_fp_if.cmp fp
);
   logic [31:0] dst_hi;   // exponent-holding words
   logic [31:0] src_hi;
   logic [62:0] mag_d;    // magnitudes without sign
   logic [62:0] mag_s;
   logic        nan_d;
   logic        nan_s;
   logic        equal;
   logic        less;

   // nan test looks at the exponent bits only
   always_comb begin
      dst_hi = fp.dst[63:32];
      src_hi = fp.src[63:32];
      nan_d  = &dst_hi[`DBF_NAN_HI:`DBF_NAN_LO];   // RULE17
      nan_s  = &src_hi[`DBF_NAN_HI:`DBF_NAN_LO];   // RULE17
      mag_d  = fp.dst[62:0];
      mag_s  = fp.src[62:0];
   end

   // sign-magnitude order, plus and minus zero are equal
   always_comb begin
      equal = (fp.dst == fp.src) || (mag_d == 63'h0 && mag_s == 63'h0);
      if (equal) begin
         less = 1'b0;
      end else if (dst_hi[`DBF_SIGN_BIT] != src_hi[`DBF_SIGN_BIT]) begin
         less = dst_hi[`DBF_SIGN_BIT];
      end else if (dst_hi[`DBF_SIGN_BIT]) begin
         less = mag_d > mag_s;
      end else begin
         less = mag_d < mag_s;
      end
   end

   // flags as destination minus source
   always_comb begin
      fp.unord = nan_d | nan_s;      // RULE21
      fp.z     = equal & ~fp.unord;  // RULE22
      fp.n     = less | fp.unord;    // RULE22
      fp.c     = less & ~fp.unord;   // RULE22
      fp.v     = fp.unord;           // RULE22
   end
endmodule : dbf_fp_cmp

// File: dbf_fp_if.sv
`timescale 1ns/1ps
interface dbf_fp_if;
   logic [63:0] dst;       // exponent word in the upper half
   logic [63:0] src;
   logic        unord;     // either operand a nan
   logic        z;
   logic        n;
   logic        c;
   logic        v;

   modport cmp (input dst, src, output unord, z, n, c, v);
   modport core (output dst, src, input unord, z, n, c, v);
endinterface : dbf_fp_if

// File: dbf_pkg.sv
package dbf_pkg;

   // decoded operation
   typedef enum logic [2:0] {
      OP_NONE,
      OP_BR_LOWER,
      OP_BR_OVF,
      OP_BR_EQ,
      OP_FLOAT_ADD_SINGLE_S,
      OP_FLOAT_ADD_SINGLE_D,
      OP_FLOAT_COMPARE_SINGLE_S,
      OP_FLOAT_COMPARE_SINGLE_D
   } dbf_op_e;

   // sequencing state
   typedef enum logic {
      ST_RUN,
      ST_SLOT
   } dbf_state_e;

   // record handed to the emulation software
   typedef struct packed {
      logic [4:0] exc;   // exceptions the op may raise
      logic       v;     // compare flags for the handler
      logic       c;
      logic       n;
      logic       z;
      logic [3:0] ls;
      logic [3:0] ld;
      dbf_op_e    op;
   } dbf_trap_s;

endpackage : dbf_pkg
